// [rtl/spi_frame_pkg.sv]
package spi_frame_pkg;

  // ----------------------------------------------------------------
  // Register offsets (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] ctrl_offset    = 8'h00;
  localparam logic [7:0] tx_data_offset = 8'h04;
  localparam logic [7:0] rx_data_offset = 8'h08;
  localparam logic [7:0] status_offset  = 8'h0c;

  // ----------------------------------------------------------------
  // Control register fields
  // ----------------------------------------------------------------
  localparam int ctrl_enable_bit   = 0;  // port_enable_bit
  localparam int ctrl_format_bit   = 1;  // 0 four-wire, 1 command/response
  localparam int ctrl_polarity_bit = 2;  // clock_polarity_sel
  localparam int ctrl_phase_bit    = 3;  // clock_phase_sel
  localparam int ctrl_clk_dir_bit  = 4;  // clock_direction_sel, 1 = input
  localparam int ctrl_frm_dir_bit  = 5;  // frame_direction_sel, 1 = input
  localparam int ctrl_cmd_wide_bit = 6;  // command_width_sel, 1 = 16 bits
  localparam int ctrl_end_tx_data_state_bit     = 7;  // end_tx_data_state, 1 = hold
  localparam int ctrl_len_lsb      = 8;  // word length minus one
  localparam int ctrl_len_msb      = 12;
  localparam int ctrl_div_lsb      = 16; // half bit period minus one
  localparam int ctrl_div_msb      = 23;

  // 8-bit words, half period of five mclk cycles, port disabled
  localparam logic [31:0] ctrl_reset = 32'h0004_0700;

  // ----------------------------------------------------------------
  // Status register fields
  // ----------------------------------------------------------------
  localparam int status_tx_full_bit = 0;
  localparam int status_rx_full_bit = 1;
  localparam int status_busy_bit    = 2;
  localparam int status_overrun_bit = 3;

  // ----------------------------------------------------------------
  // Word and command lengths in bits
  // ----------------------------------------------------------------
  localparam logic [5:0] word_len_min  = 6'h04;
  localparam logic [5:0] word_len_full = 6'h20;
  localparam logic [5:0] resp_len_max  = 6'h10;
  localparam logic [5:0] cmd_len_short = 6'h08;
  localparam logic [5:0] cmd_len_long  = 6'h10;

  // ----------------------------------------------------------------
  // Engine states
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    mode_idle,
    mode_master,
    mode_slave
  } mode_t;

endpackage

// [rtl/spi_frame_engine.sv]
// Function
// R1: Disabled: clock low, data low, frame high
// R2: Frame falls, MSB half cycle later
// R3: Default mode clock rises mid first bit
// R4: Word length four to thirty-two bits
// R5: Peripheral drives MSB first; sample rising edges
// R6: Frame rises after last bit; push word
// R7: Idle holds last bit; disable forces low
// R8: Back-to-back words, frame stays low, no gaps
// R9: Software sets clock and frame direction equal
// R10: Phase clear: full idle lead, half tail
// R11: Phase set: half idle lead, full tail
// R12: Polarity inverts clock; phase shifts it half
// R13: Equal selects drive falling; differ drive rising
// R14: Phase select ignored outside four-wire format
// R15: Receive line outside data bits is don't-care
// R16: Command format sends 8 or 16 bit command
// R17: Clock rises mid command MSB, keeps toggling
// R18: Response follows one bit after command
// R19: Last falling edge ends response, frame rises later
// R20: Back-to-back commands follow responses without gap
// R21: Command format is master only
// R22: Command end state: hold bit or zero
// R23: Response four to sixteen bits
// R24: All words shifted MSB first
// R25: Frame starts only with a transmit word waiting; slave mode starts on the frame fall without one and sends zeros
module spi_frame_engine (
  input  wire logic        mclk,
  input  wire logic        reset_n,
  input  wire logic [7:0]  address,
  input  wire logic [31:0] write_data,
  input  wire logic        write_strobe,
  input  wire logic        read_strobe,
  output logic      [31:0] read_data,
  input  wire logic        serial_bit_clock_in,
  output logic             serial_bit_clock_out,
  output logic             serial_bit_clock_oe,
  input  wire logic        frame_select_in,
  output logic             frame_select_out,
  output logic             frame_select_oe,
  output logic             tx_serial_line,
  input  wire logic        rx_serial_line
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [31:0]                 ctrl;
    logic [31:0]                 tx_word;
    logic                        tx_full;
    logic [31:0]                 rx_word;
    logic                        rx_full;
    logic                        overrun;
    logic [31:0]                 rdata;
    spi_frame_pkg::mode_t        mode;
    logic [7:0]                  hcnt;
    logic [6:0]                  ph;
    logic [5:0]                  scnt;
    logic                        fresh;
    logic [31:0]                 tx_sh;
    logic [31:0]                 rx_sh;
    logic                        tx_pin;
    logic                        sclk_pin;
    logic                        sclk_oe;
    logic                        frame_pin;
    logic                        frame_oe;
    logic                        sclk_s1;
    logic                        sclk_s2;
    logic                        sclk_s3;
    logic                        frm_s1;
    logic                        frm_s2;
    logic                        frm_s3;
    logic                        rx_s1;
    logic                        rx_s2;
  } state_t;

  state_t s;
  state_t next_s;

  // ----------------------------------------------------------------
  // Decoded configuration
  // ----------------------------------------------------------------
  logic       enabled;
  logic       cmd_fmt;
  logic       cpol;
  logic       cpha;
  logic       master_clk;
  logic       master_frm;
  logic [5:0] len_raw;
  logic [5:0] word_len;
  logic [5:0] cmd_len;
  logic [5:0] total_bits;
  logic [5:0] drive_bits;
  logic [5:0] skip_bits;
  logic [6:0] p_last;
  logic [6:0] p_drive_last;
  logic [5:0] load_shift;
  logic [31:0] load_word;
  logic       tick;
  logic       eff_clk;
  logic       eff_clk_prev;
  logic       lead_edge;
  logic       trail_edge;

  assign enabled    = s.ctrl[spi_frame_pkg::ctrl_enable_bit];
  assign cmd_fmt    = s.ctrl[spi_frame_pkg::ctrl_format_bit];
  // Polarity only shapes the four-wire format
  assign cpol       = s.ctrl[spi_frame_pkg::ctrl_polarity_bit] & ~cmd_fmt;
  assign cpha       = s.ctrl[spi_frame_pkg::ctrl_phase_bit] & ~cmd_fmt; // [R14]
  assign master_clk = ~s.ctrl[spi_frame_pkg::ctrl_clk_dir_bit];
  assign master_frm = ~s.ctrl[spi_frame_pkg::ctrl_frm_dir_bit];

  // Word length clamped to the legal range of each format
  assign len_raw = 6'(s.ctrl[spi_frame_pkg::ctrl_len_msb:
                             spi_frame_pkg::ctrl_len_lsb]) + 6'h01;
  always_comb begin
    word_len = len_raw;
    if (len_raw < spi_frame_pkg::word_len_min) begin // [R4]
      word_len = spi_frame_pkg::word_len_min;
    end
    if (cmd_fmt && len_raw > spi_frame_pkg::resp_len_max) begin // [R23]
      word_len = spi_frame_pkg::resp_len_max;
    end
  end

  // Command frame is command, one turnaround bit, then response
  assign cmd_len = s.ctrl[spi_frame_pkg::ctrl_cmd_wide_bit] ?
                   spi_frame_pkg::cmd_len_long :
                   spi_frame_pkg::cmd_len_short; // [R16]
  assign total_bits = cmd_fmt ? cmd_len + 6'h01 + word_len : word_len;
  assign drive_bits = cmd_fmt ? cmd_len : word_len;
  assign skip_bits  = cmd_fmt ? cmd_len + 6'h01 : 6'h00; // [R18]
  assign p_last       = {total_bits, 1'b0};
  assign p_drive_last = {drive_bits, 1'b0} - 7'h01;

  // Transmit word left aligned so bit 31 leaves first
  assign load_shift = spi_frame_pkg::word_len_full - drive_bits;
  assign load_word  = s.tx_full ? (s.tx_word << load_shift) : 32'h0; // [R24]

  // Half bit period enable
  assign tick = (s.hcnt == s.ctrl[spi_frame_pkg::ctrl_div_msb:
                                  spi_frame_pkg::ctrl_div_lsb]);

  // Slave clock edges seen through the synchroniser
  assign eff_clk      = s.sclk_s2 ^ cpol;
  assign eff_clk_prev = s.sclk_s3 ^ cpol;
  assign lead_edge    = eff_clk & ~eff_clk_prev;
  assign trail_edge   = ~eff_clk & eff_clk_prev;

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    logic        push;
    logic [31:0] push_word;
    logic        load;
    logic        samp_edge;
    logic        drv_edge;
    logic [6:0]  p;
    logic        cont;
    logic        toggle;
    push      = 1'b0;
    push_word = s.rx_sh;
    load      = 1'b0;
    samp_edge = cpha ? trail_edge : lead_edge; // [R13]
    drv_edge  = cpha ? lead_edge : trail_edge; // [R13]
    p         = s.ph;
    cont      = 1'b0;
    toggle    = 1'b0;
    next_s    = s;
    next_s.rdata = 32'h0;

    // Pin synchronisers, second stage is the first one read
    next_s.sclk_s1 = serial_bit_clock_in;
    next_s.sclk_s2 = s.sclk_s1;
    next_s.sclk_s3 = s.sclk_s2;
    next_s.frm_s1  = frame_select_in;
    next_s.frm_s2  = s.frm_s1;
    next_s.frm_s3  = s.frm_s2;
    next_s.rx_s1   = rx_serial_line;
    next_s.rx_s2   = s.rx_s1;
    next_s.sclk_oe  = master_clk;
    next_s.frame_oe = master_frm;

    // Register writes; a full transmit holder refuses new words
    if (write_strobe) begin
      case (address)
        spi_frame_pkg::ctrl_offset: begin
          next_s.ctrl = write_data;
        end
        spi_frame_pkg::tx_data_offset: begin
          if (!s.tx_full) begin
            next_s.tx_word = write_data;
            next_s.tx_full = 1'b1;
          end
        end
        spi_frame_pkg::status_offset: begin
          if (write_data[spi_frame_pkg::status_overrun_bit]) begin
            next_s.overrun = 1'b0;
          end
        end
        default: begin
        end
      endcase
    end

    // Register reads, answered in the next cycle only
    if (read_strobe) begin
      case (address)
        spi_frame_pkg::ctrl_offset: begin
          next_s.rdata = s.ctrl;
        end
        spi_frame_pkg::rx_data_offset: begin
          next_s.rdata   = s.rx_word;
          next_s.rx_full = 1'b0;
        end
        spi_frame_pkg::status_offset: begin
          next_s.rdata[spi_frame_pkg::status_tx_full_bit] = s.tx_full;
          next_s.rdata[spi_frame_pkg::status_rx_full_bit] = s.rx_full;
          next_s.rdata[spi_frame_pkg::status_busy_bit] =
            (s.mode != spi_frame_pkg::mode_idle);
          next_s.rdata[spi_frame_pkg::status_overrun_bit] = s.overrun;
        end
        default: begin
        end
      endcase
    end

    // Frame engine
    if (!enabled) begin
      next_s.mode      = spi_frame_pkg::mode_idle;
      next_s.sclk_pin  = 1'b0; // [R1]
      next_s.frame_pin = 1'b1; // [R1]
      next_s.tx_pin    = 1'b0; // [R1] [R7]
      next_s.hcnt      = 8'h00;
    end else begin
      unique case (s.mode)
        spi_frame_pkg::mode_idle: begin
          next_s.sclk_pin  = cpol; // [R12]
          next_s.frame_pin = 1'b1;
          next_s.hcnt      = 8'h00;
          if (master_clk && master_frm && s.tx_full) begin // [R25]
            next_s.frame_pin = 1'b0; // [R2]
            next_s.ph        = 7'h01;
            next_s.mode      = spi_frame_pkg::mode_master;
            load             = 1'b1;
          end else if (!master_clk && !master_frm && !cmd_fmt &&
                       s.frm_s3 && !s.frm_s2) begin // [R9]
            next_s.mode  = spi_frame_pkg::mode_slave;
            next_s.scnt  = 6'h00;
            next_s.fresh = cpha;
            load         = 1'b1;
            if (!cpha) begin
              next_s.tx_pin = load_word[31];
            end
          end
        end

        spi_frame_pkg::mode_master: begin
          next_s.hcnt = tick ? 8'h00 : s.hcnt + 8'h01;
          if (tick) begin
            next_s.ph = p + 7'h01;
            // Phase moves the toggle window by half a period
            toggle = cpha ? (p >= 7'h01 && p <= p_last) :
                            (p >= 7'h02 && p <= p_last + 7'h01);
            // [R3] [R10] [R11] [R17]
            // MSB goes out half a period after the frame falls
            if (p == 7'h01) begin
              next_s.tx_pin = s.tx_sh[31]; // [R2]
            end else if (p[0] && p <= p_drive_last) begin
              next_s.tx_sh  = {s.tx_sh[30:0], 1'b0};
              next_s.tx_pin = s.tx_sh[30]; // [R24]
            end
            // Even half periods carry the sampling edge
            if (!p[0] && p >= 7'h02 && p <= p_last &&
                p[6:1] > skip_bits) begin
              next_s.rx_sh = {s.rx_sh[30:0], s.rx_s2}; // [R5] [R18]
            end
            if (p == p_last + 7'h01 && s.tx_full) begin
              // Next word starts on this very edge
              cont          = 1'b1; // [R8] [R20]
              push          = 1'b1;
              load          = 1'b1;
              next_s.tx_pin = load_word[31];
              next_s.ph     = 7'h02;
            end
            if (toggle || cont) begin
              next_s.sclk_pin = ~s.sclk_pin;
            end
            if (p == p_last + 7'h02) begin
              next_s.frame_pin = 1'b1; // [R6] [R19]
              next_s.mode      = spi_frame_pkg::mode_idle;
              push             = 1'b1; // [R6]
              if (cmd_fmt &&
                  !s.ctrl[spi_frame_pkg::ctrl_end_tx_data_state_bit]) begin
                next_s.tx_pin = 1'b0; // [R22]
              end
            end
          end
        end

        spi_frame_pkg::mode_slave: begin
          if (s.frm_s2) begin
            // Frame released; line keeps its last bit
            next_s.mode = spi_frame_pkg::mode_idle; // [R7]
          end else begin
            if (drv_edge) begin
              if (s.fresh) begin
                next_s.tx_pin = s.tx_sh[31];
                next_s.fresh  = 1'b0;
              end else begin
                next_s.tx_sh  = {s.tx_sh[30:0], 1'b0};
                next_s.tx_pin = s.tx_sh[30];
              end
            end
            if (samp_edge) begin
              next_s.rx_sh = {s.rx_sh[30:0], s.rx_s2}; // [R5]
              next_s.scnt  = s.scnt + 6'h01;
              if (s.scnt + 6'h01 == word_len) begin
                // Word boundary tracked by length alone
                push         = 1'b1; // [R8]
                push_word    = {s.rx_sh[30:0], s.rx_s2};
                load         = 1'b1;
                next_s.scnt  = 6'h00;
                next_s.fresh = 1'b1;
              end
            end
          end
        end

        default: begin
          next_s.mode = spi_frame_pkg::mode_idle;
        end
      endcase
    end

    // Transmit holder to shifter; receive shifter restarts empty
    if (load) begin
      next_s.tx_sh = load_word;
      next_s.rx_sh = 32'h0;
      if (s.tx_full) begin
        next_s.tx_full = 1'b0;
      end
    end

    // Completed word; an unread word is lost and flagged
    if (push) begin
      if (next_s.rx_full) begin
        next_s.overrun = 1'b1;
      end
      next_s.rx_word = push_word;
      next_s.rx_full = 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      s           <= '0;
      s.ctrl      <= spi_frame_pkg::ctrl_reset;
      s.mode      <= spi_frame_pkg::mode_idle;
      s.frame_pin <= 1'b1;
      s.frame_oe  <= 1'b1;
      s.sclk_oe   <= 1'b1;
      s.frm_s1    <= 1'b1;
      s.frm_s2    <= 1'b1;
      s.frm_s3    <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  // Pins and read data straight from flops
  assign read_data            = s.rdata;
  assign serial_bit_clock_out = s.sclk_pin;
  assign serial_bit_clock_oe  = s.sclk_oe;
  assign frame_select_out     = s.frame_pin;
  assign frame_select_oe      = s.frame_oe;
  assign tx_serial_line       = s.tx_pin;

endmodule

// [sim/spi_frame_props.sv]
module spi_frame_props (
  input wire logic        mclk,
  input wire logic        reset_n,
  input wire logic [7:0]  address,
  input wire logic [31:0] write_data,
  input wire logic        write_strobe,
  input wire logic        serial_bit_clock_out,
  input wire logic        serial_bit_clock_oe,
  input wire logic        frame_select_out,
  input wire logic        frame_select_oe,
  input wire logic        tx_serial_line
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [31:0] ctl;
  logic [31:0] ctl_d1;
  logic [31:0] ctl_d2;
  logic [8:0]  tog;
  logic        live;
  logic        pol;
  logic        pha;
  int          len;
  int          per_word;

  // ----
  // Control shadow and frame edge count
  // ----
  // Snooped off the bus; pins lag ctrl, so checks wait two quiet cycles
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      ctl    <= spi_frame_pkg::ctrl_reset;
      ctl_d1 <= spi_frame_pkg::ctrl_reset;
      ctl_d2 <= spi_frame_pkg::ctrl_reset;
    end else begin
      if (write_strobe && address == spi_frame_pkg::ctrl_offset) begin
        ctl <= write_data;
      end
      ctl_d1 <= ctl;
      ctl_d2 <= ctl_d1;
    end
  end

  // Clock edges while frame is low
  always_ff @(posedge mclk) begin
    if (!reset_n || frame_select_out) begin
      tog <= '0;
    end else if ($changed(serial_bit_clock_out)) begin
      tog <= tog + 9'h001;
    end
  end

  // Lead and tail windows assume half period of five cycles
  always_comb begin
    live = ctl[0] && ctl == ctl_d1 && ctl_d1 == ctl_d2 && frame_select_oe
           && serial_bit_clock_oe && ctl[23:16] == 8'h04;
    pol = ctl[2] && !ctl[1];
    pha = ctl[3] && !ctl[1];
    len = (ctl[12:8] < 5'h03) ? 4 : int'(ctl[12:8]) + 1;
    per_word = ctl[1] ? 2 * ((ctl[6] ? 16 : 8) + 1 + (len > 16 ? 16 : len))
                      : 2 * len;
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!reset_n);

  AST_OFF_PINS: assert property (
    !ctl[0] [*3] |-> !serial_bit_clock_out && frame_select_out
      && !tx_serial_line) else $error("Disabled pins not idle");
  AST_IDLE_CLK: assert property (
    live && frame_select_out && $past(frame_select_out)
      |-> serial_bit_clock_out == pol) else $error("Idle clock level wrong");
  AST_LEAD_PH0: assert property (
    $fell(frame_select_out) && live && !pha |-> ##2
      $stable(serial_bit_clock_out) [*8] ##1 $changed(serial_bit_clock_out))
    else $error("Clock lead not a full bit");
  AST_LEAD_PH1: assert property (
    $fell(frame_select_out) && live && pha |-> ##1
      $stable(serial_bit_clock_out) [*4] ##1 $changed(serial_bit_clock_out))
    else $error("Clock lead not half a bit");
  AST_TAIL_PH0: assert property (
    $rose(frame_select_out) && live && !pha |->
      $past(serial_bit_clock_out, 5) != $past(serial_bit_clock_out, 6)
      && $past(serial_bit_clock_out) == $past(serial_bit_clock_out, 5))
    else $error("Frame tail not half a bit");
  AST_TAIL_PH1: assert property (
    $rose(frame_select_out) && live && pha |->
      $past(serial_bit_clock_out, 10) != $past(serial_bit_clock_out, 11)
      && $past(serial_bit_clock_out) == $past(serial_bit_clock_out, 10))
    else $error("Frame tail not a full bit");
  AST_BIT_COUNT: assert property (
    $rose(frame_select_out) && live |-> tog != 0 && tog % per_word == 0)
    else $error("Clock edge count off");
  AST_TX_SAMPLE: assert property (
    live && !frame_select_out && $changed(serial_bit_clock_out)
      && (serial_bit_clock_out ^ pol ^ pha) |-> $stable(tx_serial_line))
    else $error("Data moved on sampling edge");
endmodule

bind spi_frame_engine spi_frame_props i_spi_frame_props (
  .mclk(mclk), .reset_n(reset_n), .address(address),
  .write_data(write_data), .write_strobe(write_strobe),
  .serial_bit_clock_out(serial_bit_clock_out),
  .serial_bit_clock_oe(serial_bit_clock_oe),
  .frame_select_out(frame_select_out), .frame_select_oe(frame_select_oe),
  .tx_serial_line(tx_serial_line)
);

// [sim/spi_peripheral_model.sv]
module spi_peripheral_model (
  input  wire logic        sclk,
  input  wire logic        frm,
  input  wire logic        tx,
  input  wire logic        cpol,
  input  wire logic        cpha,
  input  wire logic [31:0] reply,
  input  wire logic [5:0]  len,
  output logic             rx,
  output logic [31:0]      heard
);
  timeunit 1ns;
  timeprecision 100ps;
  int cnt;

  // ----
  // Select and clock edges
  // ----
  initial rx = 1'b1;
  // Phase clear puts the MSB out as soon as select falls
  always @(frm) begin
    if (frm === 1'b0) begin
      cnt = 0;
      heard = '0;
      if (!cpha) rx = reply[len - 1];
    end else begin
      rx = ~rx; // No pull on the line, so never the last value
    end
  end

  // Words stream back to back, wrapping at the word length
  always @(sclk) begin
    if (frm === 1'b0) begin
      if (sclk ^ cpol ^ cpha) begin
        heard = {heard[30:0], tx};
      end else begin
        if (!cpha) cnt = cnt + 1;
        rx = reply[len - 1 - cnt % len];
        if (cpha) cnt = cnt + 1;
      end
    end
  end
endmodule

// [sim/tb.sv]
`define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin \
  failures++; $display("ERROR %s exp %h got %h", n, e, g); end end

module tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic        mclk;
  logic        reset_n;
  logic [7:0]  address;
  logic [31:0] write_data;
  logic        write_strobe;
  logic        read_strobe;
  logic [31:0] read_data;
  logic        sck_o;
  logic        sck_oe;
  logic        fs_o;
  logic        fs_oe;
  logic        txd;
  logic        rxd;
  logic        ext_clk;
  logic        ext_fs;
  logic        m_pol;
  logic        m_pha;
  logic [5:0]  m_len;
  logic [31:0] m_reply;
  logic [31:0] heard;
  logic [31:0] got;
  int          failures;
  int          cmp_count;
  int          rises;
  wire         sck_w = sck_oe ? sck_o : ext_clk;
  wire         fs_w = fs_oe ? fs_o : ext_fs;

  spi_frame_engine i_spi_frame_engine (
    .mclk(mclk), .reset_n(reset_n), .address(address),
    .write_data(write_data), .write_strobe(write_strobe),
    .read_strobe(read_strobe), .read_data(read_data),
    .serial_bit_clock_in(sck_w), .serial_bit_clock_out(sck_o),
    .serial_bit_clock_oe(sck_oe), .frame_select_in(fs_w),
    .frame_select_out(fs_o), .frame_select_oe(fs_oe),
    .tx_serial_line(txd), .rx_serial_line(rxd));
  spi_peripheral_model i_spi_peripheral_model (
    .sclk(sck_w), .frm(fs_w), .tx(txd), .cpol(m_pol), .cpha(m_pha),
    .reply(m_reply), .len(m_len), .rx(rxd), .heard(heard));

  // ----
  // Clock, bus cycles and helpers
  // ----
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  always @(posedge fs_w) rises++;

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    address <= a;
    write_data <= d;
    write_strobe <= 1'b1;
    @(posedge mclk);
    write_strobe <= 1'b0;
  endtask

  // Read data stands only in the cycle after the strobe
  task automatic rd(input logic [7:0] a);
    @(posedge mclk);
    address <= a;
    read_strobe <= 1'b1;
    @(posedge mclk);
    read_strobe <= 1'b0;
    #1 got = read_data;
  endtask

  task automatic wait_frame;
    int k;
    k = 0;
    while (fs_o !== 1'b0 && k < 100) begin
      @(posedge mclk);
      k++;
    end
    `CHK("frame start", 1'b0, fs_o)
    while (fs_o !== 1'b1 && k < 2000) begin
      @(posedge mclk);
      k++;
    end
    repeat (3) @(posedge mclk);
    `CHK("frame end", 1'b1, fs_o)
  endtask

  task automatic end_of_test;
    $display("comparisons %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // ----
  // Scenarios
  // ----
  task automatic t_reset;
    rd(spi_frame_pkg::ctrl_offset);
    `CHK("ctrl", spi_frame_pkg::ctrl_reset, got)
    rd(8'h10);
    `CHK("unmapped", 32'h0, got)
    `CHK("idle pins", 3'b010, {sck_o, fs_o, txd})
    `CHK("pin dirs", 2'b11, {sck_oe, fs_oe})
  endtask

  // Both directions master, as the far side expects
  task automatic t_spi(input logic pol, input logic pha,
                       input logic [5:0] len, input logic [31:0] w);
    logic [31:0] m;
    m = (len == 6'h20) ? 32'hffff_ffff : (32'h1 << len) - 32'h1;
    m_pol <= pol;
    m_pha <= pha;
    m_len <= len;
    m_reply <= ~w;
    wr(8'h00, {16'h0004, 3'b000, len[4:0] - 5'h01, 4'h0, pha, pol, 2'b01});
    wr(spi_frame_pkg::tx_data_offset, w);
    wait_frame;
    rd(spi_frame_pkg::rx_data_offset);
    `CHK("rx word", ~w & m, got)
    `CHK("tx word", w & m, heard & m)
    `CHK("idle pins", {pol, w[0]}, {sck_o, txd})
  endtask

  task automatic t_b2b;
    int n;
    n = rises;
    wr(spi_frame_pkg::tx_data_offset, 32'h0000_00a5);
    got = 32'h1;
    for (int k = 0; k < 50 && got[0] === 1'b1; k++) begin
      rd(spi_frame_pkg::status_offset);
    end
    wr(spi_frame_pkg::tx_data_offset, 32'h0000_003c);
    wait_frame;
    `CHK("one frame", n + 1, rises)
    `CHK("two words", 16'ha53c, heard[15:0])
    rd(spi_frame_pkg::status_offset);
    `CHK("status", 4'ha, got[3:0])
    wr(spi_frame_pkg::status_offset, 32'h0000_0008);
    rd(spi_frame_pkg::status_offset);
    `CHK("overrun clear", 1'b0, got[3])
  endtask

  // Phase and polarity set on purpose: command format must ignore them
  task automatic t_cmd(input logic wide, input logic hold,
                       input logic [5:0] rl, input logic [15:0] cmd);
    int cl;
    cl = wide ? 16 : 8;
    m_pol <= 1'b0;
    m_pha <= 1'b0;
    m_len <= 6'(cl + 1 + rl);
    m_reply <= 32'h5a5a_5a5a ^ 32'(cmd);
    wr(8'h00, {16'h0004, 3'b000, rl[4:0] - 5'h01, hold, wide, 6'h0f});
    wr(spi_frame_pkg::tx_data_offset, 32'(cmd));
    wait_frame;
    rd(spi_frame_pkg::rx_data_offset);
    `CHK("response", m_reply & ((32'h1 << rl) - 1), got)
    `CHK("command", 32'(cmd), (heard >> (rl + 1)) & ((32'h1 << cl) - 1))
    `CHK("end state", hold & cmd[0], txd)
  endtask

  task automatic t_abort;
    wr(8'h00, {16'h0004, 3'b000, 5'h07, 8'h01});
    wr(spi_frame_pkg::tx_data_offset, 32'h0000_00ff);
    repeat (30) @(posedge mclk);
    wr(8'h00, {16'h0004, 3'b000, 5'h07, 8'h00});
    repeat (3) @(posedge mclk);
    `CHK("abort pins", 3'b010, {sck_o, fs_o, txd})
  endtask

  // Link clock runs only inside the frame, off the mclk phase
  task automatic t_slave(input logic pha);
    m_pol <= 1'b0;
    m_pha <= pha;
    m_len <= 6'h08;
    m_reply <= 32'h0000_0096;
    wr(8'h00, {16'h0004, 3'b000, 5'h07, 4'h3, pha, 3'b001});
    wr(spi_frame_pkg::tx_data_offset, 32'h0000_004e);
    `CHK("slave dirs", 2'b00, {sck_oe, fs_oe})
    @(posedge mclk);
    ext_fs <= 1'b0;
    #125;
    repeat (16) #62.5 ext_clk <= ~ext_clk;
    #125;
    @(posedge mclk);
    ext_fs <= 1'b1;
    repeat (5) @(posedge mclk);
    rd(spi_frame_pkg::rx_data_offset);
    `CHK("slave rx", 32'h0000_0096, got)
    `CHK("slave tx", 8'h4e, heard[7:0])
  endtask

  // ----
  // Main sequence and watchdog
  // ----
  initial begin
    reset_n = 1'b0;
    address = 8'h00;
    write_data = 32'h0;
    write_strobe = 1'b0;
    read_strobe = 1'b0;
    ext_clk = 1'b0;
    ext_fs = 1'b1;
    m_pol = 1'b0;
    m_pha = 1'b0;
    m_len = 6'h08;
    m_reply = 32'h0;
    repeat (8) @(posedge mclk);
    reset_n <= 1'b1;
    t_reset;
    t_spi(1'b0, 1'b0, 6'h08, 32'h0000_00b4);
    t_b2b;
    t_spi(1'b0, 1'b1, 6'h08, 32'h0000_0069);
    t_spi(1'b1, 1'b0, 6'h08, 32'h0000_001e);
    t_spi(1'b1, 1'b1, 6'h20, 32'hc0de_7a51);
    t_spi(1'b0, 1'b0, 6'h04, 32'h0000_0009);
    t_cmd(1'b0, 1'b1, 6'h08, 16'h00c3);
    t_cmd(1'b1, 1'b0, 6'h0c, 16'hb2d1);
    t_abort;
    t_slave(1'b0);
    t_slave(1'b1);
    end_of_test;
  end

  // Whole run needs under 2000 cycles
  initial begin
    #100000;
    failures++;
    end_of_test;
  end
endmodule
